// [design/host_port_pkg.sv]
// Constants, register map and wait classes of the 16-bit host port.
// Assumes one 10 MHz system clock shared by both ends of the port.
// Summary of operation
// - Four read kinds, chip-select or read-strobe timed
// - Plain writes and transmit-FIFO direct writes
// - Transmit level updates within 135 ns
// - Host waits after writes before certain reads
// - Wait applies to read right after write
// - Most control registers need 165 ns wait
// - Ident, byte test, rx info, drops: no wait
// - Byte-test dummy reads fill the wait
// - Fewer dummies when time already elapsed
// - Read spans both strobes low, any order
package host_port_pkg;

    localparam int ADDR_W = 7;
    localparam int DATA_W = 16;
    localparam int REG_COUNT = 24;

    // ------------------------------------------------------------
    // Register word indices
    // ------------------------------------------------------------
    localparam logic [6:0] A_CHIP_IDENT = 7'h00;
    localparam logic [6:0] A_IRQ_CFG = 7'h01;
    localparam logic [6:0] A_INT_STATUS = 7'h02;
    localparam logic [6:0] A_INT_EN = 7'h03;
    localparam logic [6:0] A_BYTE_TEST = 7'h04;
    localparam logic [6:0] A_FIFO_INT = 7'h05;
    localparam logic [6:0] A_RX_CFG = 7'h06;
    localparam logic [6:0] A_TX_CFG = 7'h07;
    localparam logic [6:0] A_HW_CONFIG = 7'h08;
    localparam logic [6:0] A_RX_DATAPATH = 7'h09;
    localparam logic [6:0] A_RX_LEVEL = 7'h0a;
    localparam logic [6:0] A_TX_LEVEL = 7'h0b;
    localparam logic [6:0] A_PWR_CTRL = 7'h0c;
    localparam logic [6:0] A_GPIO_CFG = 7'h0d;
    localparam logic [6:0] A_TIMER_CFG = 7'h0e;
    localparam logic [6:0] A_TIMER_CNT = 7'h0f;
    localparam logic [6:0] A_WORD_SWAP = 7'h10;
    localparam logic [6:0] A_FREE_RUN = 7'h11;
    localparam logic [6:0] A_RX_DROP = 7'h12;
    localparam logic [6:0] A_MAC_CMD = 7'h13;
    localparam logic [6:0] A_MAC_DATA = 7'h14;
    localparam logic [6:0] A_FLOW_CFG = 7'h15;
    localparam logic [6:0] A_EEPROM_CMD = 7'h16;
    localparam logic [6:0] A_EEPROM_DATA = 7'h17;

    localparam logic [15:0] BYTE_TEST_VALUE = 16'h4321;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [15:0] UNMAPPED_VALUE = 16'h0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_TX_LEVEL_NS = 135;
    localparam int T_WAIT_SHORT_NS = 165;
    localparam int T_WAIT_LONG_NS = 330;
    localparam int T_CSH_NS = 13;
    // Longest time rounds down, least times round up
    localparam int TX_LEVEL_CYC = T_TX_LEVEL_NS / CLK_PERIOD_NS;
    localparam int WAIT_SHORT_CYC = (T_WAIT_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_LONG_CYC = (T_WAIT_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CSH_CYC = (T_CSH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Strobes low two cycles: device returns data one cycle after start
    localparam int STROBE_LOW_CYC = 2;
    localparam int ELAPSED_W = 3;
    localparam logic [2:0] ELAPSED_MAX = 3'h7;

    // Writable control registers; the rest are read-only state
    function automatic logic is_writable(input logic [6:0] a);
        is_writable = (a < 7'(REG_COUNT)) && (a != A_CHIP_IDENT) && (a != A_BYTE_TEST)
            && (a != A_RX_LEVEL) && (a != A_TX_LEVEL) && (a != A_FREE_RUN)
            && (a != A_RX_DROP);
    endfunction

    // Least cycles between the end of a write and the next read
    function automatic logic [2:0] wait_cycles(input logic [6:0] a);
        if (a == A_CHIP_IDENT || a == A_BYTE_TEST || a == A_RX_LEVEL || a == A_RX_DROP) begin
            wait_cycles = 3'h0;
        end else if (a == A_PWR_CTRL || a == A_FREE_RUN) begin
            wait_cycles = 3'(WAIT_LONG_CYC);
        end else begin
            wait_cycles = 3'(WAIT_SHORT_CYC);
        end
    endfunction

endpackage

// [design/host_port_if.sv]
// Pins of the SRAM-like host port between device and host ends.
// Assumes each end drives the data bus only while its enable is low.
`timescale 1ns/1ps
interface host_port_if;
    logic chip_select_n;
    logic read_strobe_n;
    logic write_strobe_n;
    logic fifo_select;
    logic [6:0] addr;
    logic [15:0] dev_data;
    logic dev_data_oe_n;
    logic [15:0] host_data;
    logic host_data_oe_n;
    logic [15:0] data_bus;

    // Resolved bus level; an undriven bus reads as zero
    assign data_bus = !dev_data_oe_n ? dev_data : (!host_data_oe_n ? host_data : 16'h0000);

    modport device (
        input chip_select_n, read_strobe_n, write_strobe_n, fifo_select, addr, data_bus,
        output dev_data, dev_data_oe_n
    );
    modport host (
        output chip_select_n, read_strobe_n, write_strobe_n, fifo_select, addr,
        output host_data, host_data_oe_n,
        input data_bus
    );
endinterface

// [design/host_port_device.sv]
// Device end of the host port: register file, FIFO taps, read returns.
// Assumes port pins are synchronous to clk_sys_in and hosts keep the waits.
`timescale 1ns/1ps
module host_port_device #(
    parameter logic [15:0] IDENT_VALUE = 16'h0a5a  // Arbitrary value
) (
    input wire logic clk_sys_in,                 // System clock
    input wire logic reset_n_in,                 // Async reset, active low
    host_port_if.device port,                    // Host port pins
    input wire logic [15:0] rx_fifo_data_in,     // Head word of receive FIFO
    input wire logic [15:0] rx_level_in,         // Receive FIFO fill level
    input wire logic [15:0] rx_drop_in,          // Dropped-frame count
    input wire logic tx_drain_in,                // Transmit FIFO word consumed
    output logic rx_pop_out,                     // Receive FIFO word taken
    output logic tx_push_out,                    // Transmit FIFO word written
    output logic [15:0] tx_data_out,             // Word for transmit FIFO
    output logic [15:0] hw_config_out,           // Hardware configuration
    output logic [15:0] power_ctrl_out           // Power management control
);

    logic rd_prev_r, rd_prev_nxt;
    logic wr_prev_r, wr_prev_nxt;
    logic [6:0] addr_lat_r, addr_lat_nxt;
    logic [15:0] data_r, data_nxt;
    logic oe_n_r, oe_n_nxt;
    logic rx_pop_r, rx_pop_nxt;
    logic tx_push_r, tx_push_nxt;
    logic [15:0] tx_data_r, tx_data_nxt;
    logic [15:0] tx_level_r, tx_level_nxt;
    logic [15:0] free_run_r, free_run_nxt;
    logic [15:0] regs_r [0:host_port_pkg::REG_COUNT-1];
    logic [15:0] regs_nxt [0:host_port_pkg::REG_COUNT-1];
    logic rd_act, wr_act, rd_start, wr_start;

    // ------------------------------------------------------------
    // Read return multiplexer
    // ------------------------------------------------------------
    function automatic logic [15:0] read_value(input logic [6:0] a);
        case (a)
            host_port_pkg::A_CHIP_IDENT: read_value = IDENT_VALUE;
            host_port_pkg::A_BYTE_TEST: read_value = host_port_pkg::BYTE_TEST_VALUE;
            host_port_pkg::A_RX_LEVEL: read_value = rx_level_in;
            host_port_pkg::A_RX_DROP: read_value = rx_drop_in;
            host_port_pkg::A_TX_LEVEL: read_value = tx_level_r;
            host_port_pkg::A_FREE_RUN: read_value = free_run_r;
            default: begin
                if (a < 7'(host_port_pkg::REG_COUNT)) begin
                    read_value = regs_r[a[4:0]];
                end else begin
                    read_value = host_port_pkg::UNMAPPED_VALUE;
                end
            end
        endcase
    endfunction

    // ------------------------------------------------------------
    // Cycle detection and register side effects
    // ------------------------------------------------------------
    // Either strobe may lead or trail; only both low counts
    assign rd_act = !port.chip_select_n && !port.read_strobe_n;
    assign wr_act = !port.chip_select_n && !port.write_strobe_n;
    // A new address under held strobes is the next word of a burst
    assign rd_start = rd_act && (!rd_prev_r || port.addr != addr_lat_r);
    assign wr_start = wr_act && !wr_prev_r;

    always_comb begin
        rd_prev_nxt = rd_act;
        wr_prev_nxt = wr_act;
        addr_lat_nxt = rd_act ? port.addr : addr_lat_r;
        data_nxt = data_r;
        oe_n_nxt = !rd_act;
        rx_pop_nxt = 1'b0;
        tx_push_nxt = 1'b0;
        tx_data_nxt = tx_data_r;
        free_run_nxt = free_run_r + 16'h0001;
        regs_nxt = regs_r;
        if (rd_start) begin
            // Values are taken at the cycle start: no wait needed
            if (port.fifo_select) begin
                data_nxt = rx_fifo_data_in;
                rx_pop_nxt = 1'b1;
            end else begin
                data_nxt = read_value(port.addr);
            end
        end
        if (wr_start) begin
            if (port.fifo_select) begin
                tx_push_nxt = 1'b1;
                tx_data_nxt = port.data_bus;
            end else if (host_port_pkg::is_writable(port.addr)) begin
                // Lands one cycle after the strobes, inside every wait
                regs_nxt[port.addr[4:0]] = port.data_bus;
            end
        end
        // Level follows a push within one cycle, under 135 ns
        tx_level_nxt = tx_level_r;
        if (wr_start && port.fifo_select && !tx_drain_in) begin
            tx_level_nxt = tx_level_r + 16'h0001;
        end else if (!(wr_start && port.fifo_select) && tx_drain_in && tx_level_r != 16'h0000) begin
            tx_level_nxt = tx_level_r - 16'h0001;
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_prev_r <= 1'b0;
            wr_prev_r <= 1'b0;
            addr_lat_r <= 7'h00;
            data_r <= 16'h0000;
            oe_n_r <= 1'b1;
            rx_pop_r <= 1'b0;
            tx_push_r <= 1'b0;
            tx_data_r <= 16'h0000;
            tx_level_r <= 16'h0000;
            free_run_r <= 16'h0000;
            for (int i = 0; i < host_port_pkg::REG_COUNT; i++) begin
                regs_r[i] <= host_port_pkg::REG_RESET;
            end
        end else begin
            rd_prev_r <= rd_prev_nxt;
            wr_prev_r <= wr_prev_nxt;
            addr_lat_r <= addr_lat_nxt;
            data_r <= data_nxt;
            oe_n_r <= oe_n_nxt;
            rx_pop_r <= rx_pop_nxt;
            tx_push_r <= tx_push_nxt;
            tx_data_r <= tx_data_nxt;
            tx_level_r <= tx_level_nxt;
            free_run_r <= free_run_nxt;
            regs_r <= regs_nxt;
        end
    end

    assign port.dev_data = data_r;
    assign port.dev_data_oe_n = oe_n_r;
    assign rx_pop_out = rx_pop_r;
    assign tx_push_out = tx_push_r;
    assign tx_data_out = tx_data_r;
    assign hw_config_out = regs_r[host_port_pkg::A_HW_CONFIG[4:0]];
    assign power_ctrl_out = regs_r[host_port_pkg::A_PWR_CTRL[4:0]];

endmodule

// [design/host_port_host.sv]
// Host end of the port: runs reads, bursts and writes, keeps write-read waits.
// Assumes the device answers a read one cycle after both strobes go low.
`timescale 1ns/1ps
module host_port_host (
    input wire logic clk_sys_in,                 // System clock
    input wire logic reset_n_in,                 // Async reset, active low
    host_port_if.host port,                      // Host port pins
    input wire logic cmd_valid_in,               // Command offered
    input wire logic cmd_write_in,               // 1 write, 0 read
    input wire logic cmd_fifo_in,                // FIFO direct access
    input wire logic [6:0] cmd_addr_in,          // Register word index
    input wire logic [3:0] cmd_burst_in,         // Extra burst words, reads
    input wire logic [15:0] cmd_wdata_in,        // Write data
    output logic cmd_ready_out,                  // Command taken this cycle
    output logic rsp_valid_out,                  // Read word returned
    output logic [15:0] rsp_data_out             // Returned word
);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LOW = 3'b010,
        ST_HIGH = 3'b100
    } host_state_t;

    host_state_t state_r, state_nxt;
    logic pend_r, pend_nxt;
    logic op_write_r, op_write_nxt;
    logic op_fifo_r, op_fifo_nxt;
    logic [6:0] op_addr_r, op_addr_nxt;
    logic [3:0] burst_r, burst_nxt;
    logic [15:0] op_wdata_r, op_wdata_nxt;
    logic dummy_r, dummy_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic [2:0] elapsed_r, elapsed_nxt;
    logic cs_n_r, cs_n_nxt;
    logic rd_n_r, rd_n_nxt;
    logic wr_n_r, wr_n_nxt;
    logic fsel_r, fsel_nxt;
    logic [6:0] addr_r, addr_nxt;
    logic oe_n_r, oe_n_nxt;
    logic rsp_valid_r, rsp_valid_nxt;
    logic [15:0] rsp_data_r, rsp_data_nxt;
    logic need_dummy;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Only reads that follow a write too soon get dummies
    assign need_dummy = !op_write_r && !op_fifo_r
        && elapsed_r < host_port_pkg::wait_cycles(op_addr_r);
    assign cmd_ready_out = (state_r == ST_IDLE) && !pend_r;

    always_comb begin
        state_nxt = state_r;
        pend_nxt = pend_r;
        op_write_nxt = op_write_r;
        op_fifo_nxt = op_fifo_r;
        op_addr_nxt = op_addr_r;
        burst_nxt = burst_r;
        op_wdata_nxt = op_wdata_r;
        dummy_nxt = dummy_r;
        cnt_nxt = cnt_r;
        cs_n_nxt = cs_n_r;
        rd_n_nxt = rd_n_r;
        wr_n_nxt = wr_n_r;
        fsel_nxt = fsel_r;
        addr_nxt = addr_r;
        oe_n_nxt = oe_n_r;
        rsp_valid_nxt = 1'b0;
        rsp_data_nxt = rsp_data_r;
        // Time since the last write, counted while anything else runs
        elapsed_nxt = (elapsed_r == host_port_pkg::ELAPSED_MAX) ? elapsed_r
            : elapsed_r + 3'h1;
        case (state_r)
            ST_IDLE: begin
                if (pend_r) begin
                    // Dummy reads of the byte test word fill a short gap
                    dummy_nxt = need_dummy;
                    addr_nxt = need_dummy ? host_port_pkg::A_BYTE_TEST : op_addr_r;
                    fsel_nxt = op_fifo_r && !need_dummy;
                    cs_n_nxt = 1'b0;
                    rd_n_nxt = op_write_r;
                    wr_n_nxt = !op_write_r;
                    oe_n_nxt = !op_write_r;
                    cnt_nxt = 2'(host_port_pkg::STROBE_LOW_CYC - 1);
                    state_nxt = ST_LOW;
                end else if (cmd_valid_in) begin
                    pend_nxt = 1'b1;
                    op_write_nxt = cmd_write_in;
                    op_fifo_nxt = cmd_fifo_in;
                    op_addr_nxt = cmd_addr_in;
                    burst_nxt = cmd_write_in ? 4'h0 : cmd_burst_in;
                    op_wdata_nxt = cmd_wdata_in;
                end
            end
            ST_LOW: begin
                if (cnt_r != 2'h0) begin
                    cnt_nxt = cnt_r - 2'h1;
                end else begin
                    if (!op_write_r && !dummy_r) begin
                        rsp_valid_nxt = 1'b1;
                        rsp_data_nxt = port.data_bus;
                    end
                    if (!op_write_r && !dummy_r && burst_r != 4'h0) begin
                        // Strobes stay low; new address marks the next word
                        burst_nxt = burst_r - 4'h1;
                        addr_nxt = addr_r + 7'h01;
                        cnt_nxt = 2'(host_port_pkg::STROBE_LOW_CYC - 1);
                    end else begin
                        cs_n_nxt = 1'b1;
                        rd_n_nxt = 1'b1;
                        wr_n_nxt = 1'b1;
                        oe_n_nxt = 1'b1;
                        cnt_nxt = 2'(host_port_pkg::CSH_CYC - 1);
                        state_nxt = ST_HIGH;
                        if (op_write_r) begin
                            elapsed_nxt = 3'h0;
                        end
                    end
                end
            end
            ST_HIGH: begin
                if (cnt_r != 2'h0) begin
                    cnt_nxt = cnt_r - 2'h1;
                end else begin
                    state_nxt = ST_IDLE;
                    if (!dummy_r) begin
                        pend_nxt = 1'b0;
                    end
                    dummy_nxt = 1'b0;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_r <= ST_IDLE;
            pend_r <= 1'b0;
            op_write_r <= 1'b0;
            op_fifo_r <= 1'b0;
            op_addr_r <= 7'h00;
            burst_r <= 4'h0;
            op_wdata_r <= 16'h0000;
            dummy_r <= 1'b0;
            cnt_r <= 2'h0;
            elapsed_r <= host_port_pkg::ELAPSED_MAX;
            cs_n_r <= 1'b1;
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            fsel_r <= 1'b0;
            addr_r <= 7'h00;
            oe_n_r <= 1'b1;
            rsp_valid_r <= 1'b0;
            rsp_data_r <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            pend_r <= pend_nxt;
            op_write_r <= op_write_nxt;
            op_fifo_r <= op_fifo_nxt;
            op_addr_r <= op_addr_nxt;
            burst_r <= burst_nxt;
            op_wdata_r <= op_wdata_nxt;
            dummy_r <= dummy_nxt;
            cnt_r <= cnt_nxt;
            elapsed_r <= elapsed_nxt;
            cs_n_r <= cs_n_nxt;
            rd_n_r <= rd_n_nxt;
            wr_n_r <= wr_n_nxt;
            fsel_r <= fsel_nxt;
            addr_r <= addr_nxt;
            oe_n_r <= oe_n_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_data_r <= rsp_data_nxt;
        end
    end

    assign port.chip_select_n = cs_n_r;
    assign port.read_strobe_n = rd_n_r;
    assign port.write_strobe_n = wr_n_r;
    assign port.fifo_select = fsel_r;
    assign port.addr = addr_r;
    assign port.host_data = op_wdata_r;
    assign port.host_data_oe_n = oe_n_r;
    assign rsp_valid_out = rsp_valid_r;
    assign rsp_data_out = rsp_data_r;

endmodule

// [sim/host_port_sva.sv]
// Pin-level checker for the host port between device and host ends.
// Assumes one clock; the bench instantiates it beside the interface.
`timescale 1ns/1ps
module host_port_sva #(
    parameter logic [15:0] IDENT_VALUE = 16'h0000
) (
    input wire logic clk_sys_in,       // Clock
    input wire logic reset_n_in,       // Reset
    input wire logic chip_select_n,    // Chip select
    input wire logic read_strobe_n,    // Read strobe
    input wire logic write_strobe_n,   // Write strobe
    input wire logic fifo_select,      // FIFO access
    input wire logic [6:0] addr,       // Word index
    input wire logic [15:0] dev_data,  // Device data
    input wire logic dev_data_oe_n,    // Device enable
    input wire logic [15:0] host_data, // Host data
    input wire logic host_data_oe_n,   // Host enable
    input wire logic [15:0] data_bus   // Resolved bus
);
    logic [2:0] gap_r;
    logic [2:0] gap_nxt;
    logic rd_act;
    logic wr_act;
    logic zero_cls;
    logic long_cls;
    assign rd_act = !chip_select_n && !read_strobe_n;
    assign wr_act = !chip_select_n && !write_strobe_n;
    assign long_cls = addr == host_port_pkg::A_PWR_CTRL || addr == host_port_pkg::A_FREE_RUN;
    assign zero_cls = addr == host_port_pkg::A_CHIP_IDENT || addr == host_port_pkg::A_BYTE_TEST
        || addr == host_port_pkg::A_RX_LEVEL || addr == host_port_pkg::A_RX_DROP;

    // ------------------------------------------------------------
    // Cycles since write strobes released, saturating
    // ------------------------------------------------------------
    always_comb begin
        gap_nxt = (gap_r == 3'h7) ? gap_r : gap_r + 3'h1;
        if (wr_act) begin
            gap_nxt = 3'h0;
        end
    end
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            gap_r <= 3'h7;
        end else begin
            gap_r <= gap_nxt;
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);

    sequence s_start;
        rd_act && !$past(rd_act);
    endsequence
    sequence s_take;
        rd_act && (!$past(rd_act) || addr != $past(addr));
    endsequence
    sequence s_end;
        rd_act ##1 !rd_act;
    endsequence

    property p_answer;
        s_take |=> !dev_data_oe_n;
    endproperty
    a_answer: assert property (p_answer) else $error("no read answer");
    property p_release;
        s_end |=> dev_data_oe_n;
    endproperty
    a_release: assert property (p_release) else $error("bus held after read");
    property p_rd_hold;
        s_start |-> rd_act [*2];
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read strobes too short");
    property p_no_clash;
        !(!dev_data_oe_n && !host_data_oe_n);
    endproperty
    a_no_clash: assert property (p_no_clash) else $error("bus contention");
    property p_wr_drive;
        wr_act |-> !host_data_oe_n && data_bus == host_data;
    endproperty
    a_wr_drive: assert property (p_wr_drive) else $error("write data not on bus");
    property p_byte_test;
        s_take ##0 (addr == host_port_pkg::A_BYTE_TEST && !fifo_select)
            |=> dev_data == host_port_pkg::BYTE_TEST_VALUE;
    endproperty
    a_byte_test: assert property (p_byte_test) else $error("byte test value wrong");
    property p_ident;
        s_take ##0 (addr == host_port_pkg::A_CHIP_IDENT && !fifo_select) |=> dev_data == IDENT_VALUE;
    endproperty
    a_ident: assert property (p_ident) else $error("ident value wrong");
    property p_wait_short;
        s_take ##0 (!fifo_select && addr < 7'h18 && !zero_cls && !long_cls) |-> gap_r >= 3'h2;
    endproperty
    a_wait_short: assert property (p_wait_short) else $error("short wait missed");
    property p_wait_long;
        s_take ##0 (!fifo_select && long_cls) |-> gap_r >= 3'h4;
    endproperty
    a_wait_long: assert property (p_wait_long) else $error("long wait missed");
endmodule

// [sim/host_port_read_after_write_rules_tb.sv]
// Bench joining device and host ends through the port interface.
// Assumes a 10 MHz clock; drives commands and device-side FIFO inputs.
`timescale 1ns/1ps
`define CHK(g, e) chk(g, e)
module host_port_read_after_write_rules_tb;
    localparam logic [15:0] ID = 16'h1234; // Arbitrary value
    localparam logic [24:0] WMASK = 25'h0f9f3ee;
    logic clk_sys_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic cmd_valid_in, cmd_write_in, cmd_fifo_in, tx_drain_in;
    logic [6:0] cmd_addr_in;
    logic [3:0] cmd_burst_in;
    logic [15:0] cmd_wdata_in, rx_fifo_data_in, rx_level_in, rx_drop_in;
    logic cmd_ready_out, rsp_valid_out, rx_pop_out, tx_push_out;
    logic [15:0] rsp_data_out, tx_data_out, hw_config_out, power_ctrl_out;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;
    int n_pop = 0;
    int n_push = 0;
    logic [15:0] rq[$];

    host_port_if port_if();
    host_port_device #(.IDENT_VALUE(ID)) host_port_device_i (.clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in), .port(port_if), .rx_fifo_data_in(rx_fifo_data_in),
        .rx_level_in(rx_level_in), .rx_drop_in(rx_drop_in), .tx_drain_in(tx_drain_in),
        .rx_pop_out(rx_pop_out), .tx_push_out(tx_push_out), .tx_data_out(tx_data_out),
        .hw_config_out(hw_config_out), .power_ctrl_out(power_ctrl_out));
    host_port_host host_port_host_i (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .port(port_if), .cmd_valid_in(cmd_valid_in), .cmd_write_in(cmd_write_in),
        .cmd_fifo_in(cmd_fifo_in), .cmd_addr_in(cmd_addr_in), .cmd_burst_in(cmd_burst_in),
        .cmd_wdata_in(cmd_wdata_in), .cmd_ready_out(cmd_ready_out),
        .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out));
    host_port_sva #(.IDENT_VALUE(ID)) host_port_sva_i (.clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in), .chip_select_n(port_if.chip_select_n),
        .read_strobe_n(port_if.read_strobe_n), .write_strobe_n(port_if.write_strobe_n),
        .fifo_select(port_if.fifo_select), .addr(port_if.addr), .dev_data(port_if.dev_data),
        .dev_data_oe_n(port_if.dev_data_oe_n), .host_data(port_if.host_data),
        .host_data_oe_n(port_if.host_data_oe_n), .data_bus(port_if.data_bus));

    always #50 clk_sys_in = ~clk_sys_in;

    task stop_test();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Monitor; one-cycle pulses are caught at their edge
    always @(posedge clk_sys_in) begin
        cyc++;
        if (rsp_valid_out === 1'b1) rq.push_back(rsp_data_out);
        if (rx_pop_out === 1'b1) n_pop++;
        if (tx_push_out === 1'b1) n_push++;
        if (cyc == 5000) begin
            n_mismatch++;
            stop_test();
        end
    end

    task chk(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    function automatic logic [15:0] get();
        if (rq.size() > 0) return rq.pop_front();
        return 16'hxxxx;
    endfunction

    function automatic logic [15:0] expv(input int i);
        case (i)
            0: expv = ID;
            4: expv = host_port_pkg::BYTE_TEST_VALUE;
            10: expv = rx_level_in;
            11: expv = 16'h0000;
            18: expv = rx_drop_in;
            default: expv = WMASK[i] ? 16'h1000 + 16'(i) : 16'h0000;
        endcase
    endfunction

    // Offer one command and hold it until the host takes it
    task cmd(input logic w, input logic f, input logic [6:0] a, input logic [3:0] b,
        input logic [15:0] d);
        int k;
        k = 0;
        @(posedge clk_sys_in);
        #1 cmd_valid_in = 1'b1;
        cmd_write_in = w;
        cmd_fifo_in = f;
        cmd_addr_in = a;
        cmd_burst_in = b;
        cmd_wdata_in = d;
        do begin
            @(posedge clk_sys_in);
            k++;
        end while (cmd_ready_out !== 1'b1 && k < 60);
        `CHK(16'(cmd_ready_out), 16'h0001);
        #1 cmd_valid_in = 1'b0;
    endtask

    task wait_rsp(input int n);
        int k;
        k = 0;
        while (rq.size() < n && k < 100) begin
            @(posedge clk_sys_in);
            #1 k++;
        end
    endtask

    task rd(input logic [6:0] a, input logic [15:0] e);
        cmd(1'b0, 1'b0, a, 4'h0, 16'h0000);
        wait_rsp(1);
        `CHK(get(), e);
    endtask

    initial begin
        {cmd_valid_in, cmd_write_in, cmd_fifo_in, tx_drain_in} = 4'h0;
        cmd_addr_in = 7'h00;
        cmd_burst_in = 4'h0;
        cmd_wdata_in = 16'h0000;
        rx_fifo_data_in = 16'h5a5a;
        rx_level_in = 16'h0007;
        rx_drop_in = 16'h0003;
        repeat (6) @(posedge clk_sys_in);
        #1 reset_n_in = 1'b1;
        rd(host_port_pkg::A_CHIP_IDENT, ID);
        rd(host_port_pkg::A_BYTE_TEST, host_port_pkg::BYTE_TEST_VALUE);
        rd(host_port_pkg::A_HW_CONFIG, 16'h0000);
        $display("test reset_reads done");
        // Indices 0 to 24, each but 17 (free run) read straight after its write
        for (int i = 0; i < 25; i++) begin
            cmd(1'b1, 1'b0, 7'(i), 4'h0, 16'h1000 + 16'(i));
            if (i != 17) rd(7'(i), expv(i));
        end
        `CHK(hw_config_out, 16'h1008);
        `CHK(power_ctrl_out, 16'h100c);
        $display("test write_read done");
        cmd(1'b1, 1'b1, 7'h00, 4'h0, 16'hbeef);
        cmd(1'b1, 1'b1, 7'h00, 4'h0, 16'hcafe);
        rd(host_port_pkg::A_TX_LEVEL, 16'h0002);
        `CHK(16'(n_push), 16'h0002);
        `CHK(tx_data_out, 16'hcafe);
        // One drain too many: level must stop at zero
        repeat (3) begin
            tx_drain_in = 1'b1;
            @(posedge clk_sys_in);
            #1 tx_drain_in = 1'b0;
            @(posedge clk_sys_in);
            #1;
        end
        rd(host_port_pkg::A_TX_LEVEL, 16'h0000);
        $display("test tx_fifo done");
        cmd(1'b0, 1'b1, 7'h00, 4'h3, 16'h0000);
        wait_rsp(4);
        repeat (4) `CHK(get(), 16'h5a5a);
        `CHK(16'(n_pop), 16'h0004);
        cmd(1'b0, 1'b0, host_port_pkg::A_HW_CONFIG, 4'h1, 16'h0000);
        wait_rsp(2);
        `CHK(get(), 16'h1008);
        `CHK(get(), 16'h1009);
        $display("test burst done");
        stop_test();
    end
endmodule
